/* design/tic_tx_int_ctrl.sv */
// transmit interrupt control register bank with slot assigner and thresholds
//
// The register offsets and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module tic_tx_int_ctrl (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wr_data,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rd_data,
  input  wire logic        sync_mode,
  input  wire logic        ev_preamble_sent,
  input  wire logic        ev_idle_sent,
  input  wire logic        ev_abort_sent,
  input  wire logic        ev_frame_end_sent,
  input  wire logic        ev_checksum_sent,
  input  wire logic        ev_underrun,
  input  wire logic [7:0]  queue_empty_count,
  input  wire logic        frame_sync,
  input  wire logic        byte_slot,
  input  wire logic        frame_start,
  output logic             irq,
  output logic             tx_data_req,
  output logic             tx_dma_req,
  output logic             tx_slot_enable,
  output logic             tx_slot_active,
  output logic      [2:0]  tx_slot_offset,
  output logic             frame_permit,
  output logic             baud1_tick
);

  ////////////////////////////////////////////////////////////////////////////
  // reset release
  logic rst_meta_reg;
  logic rst_sync_reg;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // decode
  logic wr_ctrl;
  logic wr_cmd;
  logic wr_status;
  logic wr_baud;
  logic [3:0] cmd_code;

  always_comb begin
    wr_ctrl   = 1'b0;
    wr_cmd    = 1'b0;
    wr_status = 1'b0;
    wr_baud   = 1'b0;
    if (reg_addr == tic_pkg::OFS_TX_INT_CTRL) begin
      wr_ctrl = reg_wr;
    end else if (reg_addr == tic_pkg::OFS_TX_CMD) begin
      wr_cmd = reg_wr;
    end else if (reg_addr == tic_pkg::OFS_TX_STATUS) begin
      wr_status = reg_wr;
    end else if (reg_addr == tic_pkg::OFS_BAUD1) begin
      wr_baud = reg_wr;
    end
  end

  assign cmd_code = reg_wr_data[tic_pkg::CMD_LSB +: 4];

  ////////////////////////////////////////////////////////////////////////////
  // upper byte context, selected by the last select command
  tic_pkg::tic_ctx_t ctx_reg;
  tic_pkg::tic_ctx_t ctx_next;
  logic [3:0]        last_cmd_reg;

  always_comb begin
    ctx_next = ctx_reg;
    if (wr_cmd) begin
      case (cmd_code)
        tic_pkg::CMD_SEL_SLOT:  ctx_next = tic_pkg::TIC_CTX_SLOT;
        tic_pkg::CMD_SEL_EMPTY: ctx_next = tic_pkg::TIC_CTX_EMPTY;
        tic_pkg::CMD_SEL_INTR:  ctx_next = tic_pkg::TIC_CTX_INTR;
        tic_pkg::CMD_SEL_DMA:   ctx_next = tic_pkg::TIC_CTX_DMA;
        default:                ctx_next = ctx_reg;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      ctx_reg      <= tic_pkg::TIC_CTX_EMPTY;
      last_cmd_reg <= tic_pkg::CMD_RST;
    end else if (clk_en) begin
      ctx_reg <= ctx_next;
      if (wr_cmd) begin
        last_cmd_reg <= cmd_code;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // low byte: arm bits, hold option, readback select
  logic [7:0] ctrl_low_reg;

  always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      ctrl_low_reg <= tic_pkg::CTRL_LOW_RST;
    end else if (clk_en && wr_ctrl) begin
      ctrl_low_reg <= reg_wr_data[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // upper byte storage per context
  logic [7:0] intr_thresh_reg;
  logic [7:0] dma_thresh_reg;
  logic [6:0] slot_start_reg;
  logic [3:0] slot_span_reg;
  logic [2:0] slot_offset_reg;

  always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      intr_thresh_reg <= tic_pkg::THRESH_RST;
      dma_thresh_reg  <= tic_pkg::THRESH_RST;
    end else if (clk_en && wr_ctrl) begin
      if (ctx_reg == tic_pkg::TIC_CTX_INTR) begin
        intr_thresh_reg <= reg_wr_data[15:8];
      end
      if (ctx_reg == tic_pkg::TIC_CTX_DMA) begin
        dma_thresh_reg <= reg_wr_data[15:8];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      slot_start_reg  <= tic_pkg::SLOT_RST;
      slot_span_reg   <= tic_pkg::SPAN_RST;
      slot_offset_reg <= tic_pkg::OFFSET_RST;
    end else if (clk_en && wr_ctrl && ctx_reg == tic_pkg::TIC_CTX_SLOT) begin
      if (reg_wr_data[tic_pkg::SLOT_SEL_BIT]) begin
        slot_span_reg   <= reg_wr_data[tic_pkg::SPAN_LSB +: 4];
        slot_offset_reg <= reg_wr_data[tic_pkg::OFFSET_LSB +: 3];
      end else begin
        slot_start_reg <= reg_wr_data[tic_pkg::SLOT_LSB +: 7];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit slot assigner
  logic [7:0] slot_idx_reg;
  logic [7:0] slot_first;
  logic [7:0] slot_end;
  logic       slot_active_reg;

  assign slot_first = {1'b0, slot_start_reg};
  assign slot_end   = slot_first + {4'h0, slot_span_reg};

  always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      slot_idx_reg <= tic_pkg::SLOT_IDX_RST;
    end else if (clk_en) begin
      if (frame_sync) begin
        slot_idx_reg <= tic_pkg::SLOT_IDX_RST;
      end else if (byte_slot && slot_idx_reg != tic_pkg::SLOT_IDX_MAX) begin
        slot_idx_reg <= slot_idx_reg + 8'h01;
      end
    end
  end

  // consecutive window [start, start+span); zero span keeps it shut
  always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      slot_active_reg <= 1'b0;
    end else if (clk_en) begin
      slot_active_reg <= (slot_span_reg != 4'h0) && !frame_sync &&
                         (slot_idx_reg >= slot_first) &&
                         (slot_idx_reg < slot_end);
    end
  end

  assign tx_slot_enable = (slot_span_reg != 4'h0);
  assign tx_slot_active = slot_active_reg;
  assign tx_slot_offset = slot_offset_reg;

  ////////////////////////////////////////////////////////////////////////////
  // queue threshold requests
  logic data_req_reg;
  logic dma_req_reg;

  always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      data_req_reg <= 1'b0;
      dma_req_reg  <= 1'b0;
    end else if (clk_en) begin
      data_req_reg <= (queue_empty_count > intr_thresh_reg);
      dma_req_reg  <= (queue_empty_count > dma_thresh_reg);
    end
  end

  assign tx_data_req = data_req_reg;
  assign tx_dma_req  = dma_req_reg;

  ////////////////////////////////////////////////////////////////////////////
  // sticky event flags, write one to clear, set wins
  logic [7:0] status_reg;
  logic [7:0] events;
  logic [7:0] arm_live;
  logic       irq_reg;

  always_comb begin
    events                         = 8'h00;
    events[tic_pkg::BIT_PREAMBLE]  = ev_preamble_sent;
    events[tic_pkg::BIT_IDLE]      = ev_idle_sent;
    events[tic_pkg::BIT_ABORT]     = ev_abort_sent;
    events[tic_pkg::BIT_FRAME_END] = ev_frame_end_sent;
    events[tic_pkg::BIT_CHECKSUM]  = ev_checksum_sent;
    events[tic_pkg::BIT_UNDERRUN]  = ev_underrun;
  end

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_flag
      if (tic_pkg::EVENT_MASK[gi]) begin : g_live
        always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
          if (!rst_sync_reg) begin
            status_reg[gi] <= tic_pkg::STATUS_RST[gi];
          end else if (clk_en) begin
            if (events[gi]) begin
              status_reg[gi] <= 1'b1;
            end else if (wr_status && reg_wr_data[gi]) begin
              status_reg[gi] <= 1'b0;
            end
          end
        end
      end else begin : g_none
        assign status_reg[gi] = 1'b0;
      end
    end
  endgenerate

  // preamble and checksum arms count only in sync modes
  always_comb begin
    arm_live = ctrl_low_reg & tic_pkg::EVENT_MASK;
    if (!sync_mode) begin
      arm_live = arm_live & ~tic_pkg::SYNC_ONLY_MASK;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      irq_reg <= 1'b0;
    end else if (clk_en) begin
      irq_reg <= |(status_reg & arm_live);
    end
  end

  assign irq = irq_reg;

  ////////////////////////////////////////////////////////////////////////////
  // frame hold until send-frame command
  logic released_reg;

  always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      released_reg <= 1'b0;
    end else if (clk_en) begin
      if (wr_cmd && cmd_code == tic_pkg::CMD_SEND_FRAME) begin
        released_reg <= 1'b1;
      end else if (frame_start) begin
        released_reg <= 1'b0;
      end
    end
  end

  assign frame_permit = !(ctrl_low_reg[tic_pkg::BIT_HOLD] && sync_mode) ||
                        released_reg;

  ////////////////////////////////////////////////////////////////////////////
  // baud generator 1 and its readback
  logic [15:0] tc_reg;
  logic [15:0] baud_count;

  always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      tc_reg <= tic_pkg::TC_RST;
    end else if (clk_en && wr_baud) begin
      tc_reg <= reg_wr_data;
    end
  end

  tic_baud_gen u_baud1 (
    .ref_clk    (ref_clk),
    .rst_n      (rst_sync_reg),
    .clk_en     (clk_en),
    .time_const (tc_reg),
    .count      (baud_count),
    .tick       (baud1_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // read port
  logic [15:0] rd_data_reg;
  logic [15:0] rd_value;
  logic [7:0]  upper_value;

  always_comb begin
    case (ctx_reg)
      tic_pkg::TIC_CTX_SLOT:  upper_value = {slot_start_reg, 1'b0};
      tic_pkg::TIC_CTX_INTR:  upper_value = intr_thresh_reg;
      tic_pkg::TIC_CTX_DMA:   upper_value = dma_thresh_reg;
      default:                upper_value = queue_empty_count;
    endcase
  end

  always_comb begin
    rd_value = 16'h0000;
    if (reg_addr == tic_pkg::OFS_TX_INT_CTRL) begin
      rd_value = {upper_value, ctrl_low_reg};
    end else if (reg_addr == tic_pkg::OFS_TX_CMD) begin
      rd_value = {last_cmd_reg, 12'h000};
    end else if (reg_addr == tic_pkg::OFS_TX_STATUS) begin
      rd_value = {8'h00, status_reg};
    end else if (reg_addr == tic_pkg::OFS_BAUD1) begin
      // captured at the read strobe
      rd_value = ctrl_low_reg[tic_pkg::BIT_READBACK] ? baud_count : tc_reg;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      rd_data_reg <= 16'h0000;
    end else if (clk_en) begin
      rd_data_reg <= reg_rd ? rd_value : 16'h0000;
    end
  end

  assign reg_rd_data = rd_data_reg;

endmodule // tic_tx_int_ctrl

`default_nettype wire

/* design/tic_pkg.sv */
// constants and types for the transmit interrupt control block
package tic_pkg;

  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 16;

  // register offsets on the plain register port
  localparam logic [3:0] OFS_TX_INT_CTRL = 4'h0;
  localparam logic [3:0] OFS_TX_CMD      = 4'h2;
  localparam logic [3:0] OFS_TX_STATUS   = 4'h4;
  localparam logic [3:0] OFS_BAUD1       = 4'h6;

  // low byte bit positions of tx_interrupt_control
  localparam int unsigned BIT_PREAMBLE  = 7;
  localparam int unsigned BIT_IDLE      = 6;
  localparam int unsigned BIT_ABORT     = 5;
  localparam int unsigned BIT_FRAME_END = 4;
  localparam int unsigned BIT_CHECKSUM  = 3;
  localparam int unsigned BIT_HOLD      = 2;
  localparam int unsigned BIT_UNDERRUN  = 1;
  localparam int unsigned BIT_READBACK  = 0;

  // upper byte field positions in the slot assigner context
  localparam int unsigned SLOT_SEL_BIT = 8;
  localparam int unsigned SLOT_LSB     = 9;
  localparam int unsigned SPAN_LSB     = 9;
  localparam int unsigned OFFSET_LSB   = 13;

  // tx_command_field position and codes
  localparam int unsigned CMD_LSB        = 12;
  localparam logic [3:0]  CMD_SEND_FRAME = 4'h2;
  localparam logic [3:0]  CMD_SEL_SLOT   = 4'h4;
  localparam logic [3:0]  CMD_SEL_EMPTY  = 4'h5;
  localparam logic [3:0]  CMD_SEL_INTR   = 4'h6;
  localparam logic [3:0]  CMD_SEL_DMA    = 4'h7;

  // event bits held in the status register, and those live only in sync modes
  localparam logic [7:0] EVENT_MASK     = 8'hfa;
  localparam logic [7:0] SYNC_ONLY_MASK = 8'h88;

  // values after reset, and the limit at which the slot index stops
  localparam logic [7:0]  CTRL_LOW_RST = 8'h00;
  localparam logic [7:0]  STATUS_RST   = 8'h00;
  localparam logic [7:0]  THRESH_RST   = 8'h00;
  localparam logic [6:0]  SLOT_RST     = 7'h00;
  localparam logic [3:0]  SPAN_RST     = 4'h0;
  localparam logic [2:0]  OFFSET_RST   = 3'h0;
  localparam logic [3:0]  CMD_RST      = 4'h0;
  localparam logic [15:0] TC_RST       = 16'h0000;
  localparam logic [7:0]  SLOT_IDX_RST = 8'h00;
  localparam logic [7:0]  SLOT_IDX_MAX = 8'hff;

  typedef enum logic [1:0] {
    TIC_CTX_EMPTY = 2'b00,
    TIC_CTX_SLOT  = 2'b01,
    TIC_CTX_INTR  = 2'b11,
    TIC_CTX_DMA   = 2'b10
  } tic_ctx_t;

endpackage

/* design/tic_baud_gen.sv */
// baud rate generator 1: reloading down counter
`timescale 1ns/1ps
`default_nettype none

module tic_baud_gen (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  input  wire logic [15:0] time_const,
  output logic      [15:0] count,
  output logic             tick
);

  logic [15:0] count_reg;
  logic        tick_reg;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= tic_pkg::TC_RST;
      tick_reg  <= 1'b0;
    end else if (clk_en) begin
      if (count_reg == 16'h0000) begin
        count_reg <= time_const;
        tick_reg  <= 1'b1;
      end else begin
        count_reg <= count_reg - 16'h0001;
        tick_reg  <= 1'b0;
      end
    end
  end

  assign count = count_reg;
  assign tick  = tick_reg;

endmodule // tic_baud_gen

`default_nettype wire

/* test/tic_tx_int_ctrl_properties.sv */
// assertion checker for the transmit interrupt control block
`timescale 1ns/1ps
`default_nettype none
module tic_chk (
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic [3:0]  reg_addr,
  input wire logic [15:0] reg_wr_data,
  input wire logic        reg_wr,
  input wire logic        ev_preamble_sent,
  input wire logic        ev_idle_sent,
  input wire logic        ev_abort_sent,
  input wire logic        ev_frame_end_sent,
  input wire logic        ev_checksum_sent,
  input wire logic        ev_underrun,
  input wire logic [7:0]  queue_empty_count,
  input wire logic        frame_sync,
  input wire logic        sync_mode,
  input wire logic        irq,
  input wire logic        tx_data_req,
  input wire logic        tx_dma_req,
  input wire logic        tx_slot_enable,
  input wire logic        tx_slot_active,
  input wire logic        frame_permit
);
  wire logic ev_any;
  wire logic ctl_wr;
  assign ev_any = ev_preamble_sent | ev_idle_sent | ev_abort_sent | ev_frame_end_sent
                  | ev_checksum_sent | ev_underrun;
  assign ctl_wr = reg_wr && reg_addr == tic_pkg::OFS_TX_INT_CTRL;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////
  property p_send_cmd;
    reg_wr && reg_addr == tic_pkg::OFS_TX_CMD
      && reg_wr_data[15:12] == tic_pkg::CMD_SEND_FRAME |=> frame_permit;
  endproperty
  a_send_cmd: assert property (p_send_cmd)
    else $error("no frame permit after send command");
  property p_async_permit;
    !sync_mode |-> frame_permit;
  endproperty
  a_async_permit: assert property (p_async_permit)
    else $error("frame held outside sync mode");
  property p_slot_sync;
    $past(frame_sync) |-> !tx_slot_active;
  endproperty
  a_slot_sync: assert property (p_slot_sync)
    else $error("slot active right after frame sync");
  property p_slot_off;
    tx_slot_active |-> $past(tx_slot_enable);
  endproperty
  a_slot_off: assert property (p_slot_off)
    else $error("slot active with assigner disabled");
  property p_req_none;
    $past(queue_empty_count) == 8'h00 |-> !tx_data_req && !tx_dma_req;
  endproperty
  a_req_none: assert property (p_req_none)
    else $error("request with no empty entries");
  property p_irq_cause;
    $rose(irq) |-> $past(ev_any, 2) || $past(reg_wr, 2)
      || $past(sync_mode) != $past(sync_mode, 2);
  endproperty
  a_irq_cause: assert property (p_irq_cause)
    else $error("irq rose without event or write");
  property p_irq_disarm;
    ctl_wr && reg_wr_data[7:0] == 8'h00 |-> ##2 !irq;
  endproperty
  a_irq_disarm: assert property (p_irq_disarm)
    else $error("irq stays after arms cleared");
  property p_irq_hold;
    irq && !ctl_wr && !reg_wr && !$past(reg_wr) && $stable(sync_mode) |=> irq;
  endproperty
  a_irq_hold: assert property (p_irq_hold)
    else $error("irq dropped without any write");
endmodule // tic_chk
bind tic_tx_int_ctrl tic_chk tic_chk_inst (
  .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
  .reg_wr(reg_wr), .ev_preamble_sent(ev_preamble_sent), .ev_idle_sent(ev_idle_sent),
  .ev_abort_sent(ev_abort_sent), .ev_frame_end_sent(ev_frame_end_sent),
  .ev_checksum_sent(ev_checksum_sent), .ev_underrun(ev_underrun),
  .queue_empty_count(queue_empty_count), .frame_sync(frame_sync), .sync_mode(sync_mode),
  .irq(irq), .tx_data_req(tx_data_req), .tx_dma_req(tx_dma_req),
  .tx_slot_enable(tx_slot_enable), .tx_slot_active(tx_slot_active),
  .frame_permit(frame_permit));
`default_nettype wire

/* test/tic_tx_int_ctrl_tb.sv */
// self-checking bench for the transmit interrupt control block
`timescale 1ns/1ps
`default_nettype none
module tic_tx_int_ctrl_tb;
  logic        ref_clk, rst_n, clk_en, reg_wr, reg_rd, sync_mode;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wr_data, reg_rd_data, v;
  logic [7:0]  ev_vec, queue_empty_count, m;
  logic [2:0]  ctl_vec;
  logic        irq, tx_data_req, tx_dma_req, tx_slot_enable, tx_slot_active;
  logic        frame_permit, baud1_tick;
  logic [2:0]  tx_slot_offset;
  logic [7:0]  ev_tab [6] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h02};
  int          n_errors, cmp_count, n;

  tic_tx_int_ctrl tic_tx_int_ctrl_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wr_data(reg_wr_data), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rd_data(reg_rd_data),
    .sync_mode(sync_mode), .ev_preamble_sent(ev_vec[7]), .ev_idle_sent(ev_vec[6]),
    .ev_abort_sent(ev_vec[5]), .ev_frame_end_sent(ev_vec[4]),
    .ev_checksum_sent(ev_vec[3]), .ev_underrun(ev_vec[1]),
    .queue_empty_count(queue_empty_count), .frame_sync(ctl_vec[1]),
    .byte_slot(ctl_vec[0]), .frame_start(ctl_vec[2]), .irq(irq),
    .tx_data_req(tx_data_req), .tx_dma_req(tx_dma_req), .tx_slot_enable(tx_slot_enable),
    .tx_slot_active(tx_slot_active), .tx_slot_offset(tx_slot_offset),
    .frame_permit(frame_permit), .baud1_tick(baud1_tick));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic chb(input string nm, input logic e, input logic g);
    chk(nm, {15'h0000, e}, {15'h0000, g});
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wr_data <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rd_data;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [15:0] e, input string nm);
    logic [15:0] d;
    rd(a, d);
    chk(nm, e, d);
  endtask
  task automatic pls(input logic [7:0] e, input logic [2:0] c);
    @(posedge ref_clk);
    ev_vec <= e;
    ctl_vec <= c;
    @(posedge ref_clk);
    ev_vec <= 8'h00;
    ctl_vec <= 3'h0;
  endtask
  task automatic qchk(input logic [7:0] q, input logic d, input logic x);
    @(posedge ref_clk);
    queue_empty_count <= q;
    cyc(3);
    chb("data req", d, tx_data_req);
    chb("dma req", x, tx_dma_req);
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    $display("BAD watchdog exp finish got timeout");
    test_done();
  end
  initial begin
    {clk_en, rst_n, reg_wr, reg_rd, sync_mode} = 5'h10;
    {reg_addr, reg_wr_data, ev_vec, ctl_vec} = 31'h00000000;
    queue_empty_count = 8'h1c;
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rdc(tic_pkg::OFS_TX_INT_CTRL, {8'h1c, tic_pkg::CTRL_LOW_RST}, "ctrl reset");
    rdc(tic_pkg::OFS_TX_STATUS, 16'h0000, "status reset");
    rdc(4'h8, 16'h0000, "unmapped");
    $display("reset test done");
    @(posedge ref_clk) sync_mode <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      m = ev_tab[i];
      wr(tic_pkg::OFS_TX_INT_CTRL, {8'h00, m});
      pls(m, 3'h0);
      cyc(3);
      chb("irq armed", 1'b1, irq);
      wr(tic_pkg::OFS_TX_INT_CTRL, 16'h0000);
      cyc(3);
      chb("irq disarmed", 1'b0, irq);
      rdc(tic_pkg::OFS_TX_STATUS, {8'h00, m}, "status set");
      wr(tic_pkg::OFS_TX_STATUS, {8'h00, m});
      rdc(tic_pkg::OFS_TX_STATUS, 16'h0000, "status clear");
    end
    @(posedge ref_clk) sync_mode <= 1'b0;
    wr(tic_pkg::OFS_TX_INT_CTRL, 16'h0088);
    pls(8'h88, 3'h0);
    cyc(3);
    chb("irq sync only", 1'b0, irq);
    wr(tic_pkg::OFS_TX_STATUS, 16'h00ff);
    wr(tic_pkg::OFS_TX_INT_CTRL, 16'h0000);
    @(posedge ref_clk) sync_mode <= 1'b1;
    $display("interrupt test done");
    wr(tic_pkg::OFS_TX_CMD, {tic_pkg::CMD_SEL_INTR, 12'h000});
    wr(tic_pkg::OFS_TX_INT_CTRL, 16'h1000);
    rdc(tic_pkg::OFS_TX_INT_CTRL, 16'h1000, "data threshold");
    qchk(8'h10, 1'b0, 1'b1);
    qchk(8'h11, 1'b1, 1'b1);
    wr(tic_pkg::OFS_TX_CMD, {tic_pkg::CMD_SEL_DMA, 12'h000});
    wr(tic_pkg::OFS_TX_INT_CTRL, 16'h0500);
    rdc(tic_pkg::OFS_TX_INT_CTRL, 16'h0500, "dma threshold");
    qchk(8'h05, 1'b0, 1'b0);
    qchk(8'h06, 1'b0, 1'b1);
    qchk(8'h00, 1'b0, 1'b0);
    wr(tic_pkg::OFS_TX_CMD, {tic_pkg::CMD_SEL_EMPTY, 12'h000});
    wr(tic_pkg::OFS_TX_INT_CTRL, 16'hff00);
    rdc(tic_pkg::OFS_TX_INT_CTRL, 16'h0000, "empty count ro");
    rdc(tic_pkg::OFS_TX_CMD, 16'h5000, "last command");
    $display("threshold test done");
    wr(tic_pkg::OFS_TX_INT_CTRL, 16'h0004);
    cyc(2);
    chb("held", 1'b0, frame_permit);
    wr(tic_pkg::OFS_TX_CMD, {tic_pkg::CMD_SEND_FRAME, 12'h000});
    cyc(0);
    chb("released", 1'b1, frame_permit);
    pls(8'h00, 3'h4);
    cyc(2);
    chb("held again", 1'b0, frame_permit);
    @(posedge ref_clk) sync_mode <= 1'b0;
    cyc(1);
    chb("async free", 1'b1, frame_permit);
    @(posedge ref_clk) sync_mode <= 1'b1;
    $display("hold test done");
    wr(tic_pkg::OFS_TX_CMD, {tic_pkg::CMD_SEL_SLOT, 12'h000});
    wr(tic_pkg::OFS_TX_INT_CTRL, 16'h0400);
    wr(tic_pkg::OFS_TX_INT_CTRL, 16'ha700);
    cyc(1);
    chb("slot enable", 1'b1, tx_slot_enable);
    chk("slot offset", 16'h0005, {13'h0000, tx_slot_offset});
    rdc(tic_pkg::OFS_TX_INT_CTRL, 16'h0400, "slot start");
    pls(8'h00, 3'h2);
    for (int k = 0; k < 7; k++) begin
      cyc(1);
      chb("slot active", k >= 2 && k < 5, tx_slot_active);
      pls(8'h00, 3'h1);
    end
    wr(tic_pkg::OFS_TX_INT_CTRL, 16'h0100);
    cyc(1);
    chb("slot disabled", 1'b0, tx_slot_enable);
    chb("slot idle", 1'b0, tx_slot_active);
    $display("slot test done");
    wr(tic_pkg::OFS_BAUD1, 16'h0009);
    rdc(tic_pkg::OFS_BAUD1, 16'h0009, "time constant");
    wr(tic_pkg::OFS_TX_INT_CTRL, 16'h0001);
    rd(tic_pkg::OFS_BAUD1, v);
    chb("count range", 1'b1, v <= 16'h0009);
    for (n = 0; n < 40 && baud1_tick !== 1'b1; n++) cyc(1);
    for (n = 1; n < 40; n++) begin
      cyc(1);
      if (baud1_tick === 1'b1) break;
    end
    chk("baud period", 16'h000a, 16'(n));
    rd(tic_pkg::OFS_BAUD1, v);
    chk("captured count", 16'h0008, v);
    $display("baud test done");
    @(posedge ref_clk) clk_en <= 1'b0;
    wr(tic_pkg::OFS_TX_INT_CTRL, 16'h0040);
    @(posedge ref_clk) clk_en <= 1'b1;
    rdc(tic_pkg::OFS_TX_INT_CTRL, 16'h0001, "frozen write");
    $display("enable test done");
    test_done();
  end
endmodule // tic_tx_int_ctrl_tb
`default_nettype wire
